// ===== src/ccd_config_pins.sv
// Functional notes
// [R01] Passive schemes: external host supplies config clock and shifts data in.
// [R02] Passive schemes: data captured on rising edge of incoming config clock.
// [R03] Active serial: device drives config clock timing all transfers.
// [R04] Active parallel: device drives config clock providing interface timing.
// [R05] Active schemes: config clock driven inactive after configuration completes.
// [R06] Active schemes: config clock pin optionally released as user I/O.
// [R07] Passive schemes: host holds config clock steady after configuration.
// [R08] Passive schemes: config clock never offered as user I/O.
// [R09] Clock toggling after configuration never disturbs device nor restarts loading.
// [R10] Serial schemes: one bit per clock on data pin zero.
// [R11] After active serial: data pin zero stays dedicated input, optional user control.
// [R12] After passive serial or parallel: data pin zero becomes user I/O.
// [R13] After active parallel: data pin zero stays dedicated bidirectional pin.
// [R14] Active serial: data pin one drives command stream to serial memory.
// [R15] Other schemes: data pin one is a configuration data input. In passive serial the code samples only data pin zero.
// [R16] After active serial: data pin one stays dedicated output.
// [R17] Passive serial: data pin one tri-stated during configuration.
// [R18] After fast passive parallel: data pin one becomes user I/O.
// [R19] Active parallel: data moves a byte or 16-bit word per clock.
// [R20] After active parallel: data pin one stays dedicated bidirectional pin.
// [R21] Done output released once all data arrived without error.
// [R22] External party holds chip enable low to allow configuration.
// [R23] Active serial: device drives chip select enabling serial memory.
// [R24] Scheme input decides clock direction and low data pin roles.
`timescale 1ns/100ps
`default_nettype none
`include "ccd_consts.svh"

module ccd_config_pins
    import ccd_pkg::*;
#(
    parameter int WORD_BITS = 16,
    parameter logic [31:0] LOAD_WORDS = 32'd4096
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Setup
    input wire logic [1:0] schemeSel,
    input wire logic apWordWide,
    input wire logic startLoad,
    input wire logic loadError,
    input wire logic chip_enable_in_n,
    // Post-configuration user control of dual-purpose pins
    input wire logic userClkOwn,
    input wire ccd_drive_type userClk,
    input wire ccd_drive_type userData0,
    input wire ccd_drive_type userData1,
    // Config clock pin
    input wire logic config_clock_i,
    output logic config_clock_o,
    output logic config_clock_oe,
    // Data pins
    input wire logic [WORD_BITS-1:0] dataPin_i,
    output logic [1:0] dataPin_o,
    output logic [1:0] dataPin_oe,
    // Serial memory select and done
    output logic serial_memory_select_n,
    output logic load_complete_flag_o,
    output logic load_complete_flag_oe,
    output logic userMode,
    output logic [WORD_BITS-1:0] pinReadback,
    // Loaded data stream
    output logic wordValid,
    input wire logic wordReady,
    output ccd_word_type wordOut
);

    // ***************************************************************
    // Input synchronisers
    // ***************************************************************
    logic clkMeta_r;
    logic clkSync_r;
    logic clkSyncD_r;
    logic ceMeta_r;
    logic ceSync_r;
    logic [WORD_BITS-1:0] datMeta_r;
    logic [WORD_BITS-1:0] datSync_r;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clkMeta_r <= 1'b0;
            clkSync_r <= 1'b0;
            clkSyncD_r <= 1'b0;
            ceMeta_r <= 1'b1;
            ceSync_r <= 1'b1;
            datMeta_r <= '0;
            datSync_r <= '0;
        end else begin
            clkMeta_r <= config_clock_i;
            clkSync_r <= clkMeta_r;
            clkSyncD_r <= clkSync_r;
            ceMeta_r <= chip_enable_in_n;
            ceSync_r <= ceMeta_r;
            datMeta_r <= dataPin_i;
            datSync_r <= datMeta_r;
        end
    end

    // Data and clock share the same two-stage delay, so the sampled bit lines up with the edge
    logic extRise;
    assign extRise = clkSync_r && !clkSyncD_r;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        ccd_phase_type phase;
        ccd_scheme_type scheme;
        logic wide;
        logic [3:0] divCnt;
        logic clkOut;
        logic [5:0] hdrCnt;
        logic [4:0] bitCnt;
        logic [15:0] shift;
        logic [31:0] wordCnt;
        logic wrValid;
        ccd_word_type wrWord;
        logic doneRel;
    } ccd_state_type;

    ccd_state_type s_r;
    ccd_state_type s_nxt;
    logic bufReady;
    logic serialMode;
    logic activeMode;
    logic lastBit;
    logic intRise;
    logic intFall;
    logic [4:0] unitBits;

    assign serialMode = (s_r.scheme == CCD_PS) || (s_r.scheme == CCD_AS);
    assign activeMode = (s_r.scheme == CCD_AS) || (s_r.scheme == CCD_AP);
    assign unitBits = serialMode ? 5'h10 : 5'h01;
    assign lastBit = (s_r.bitCnt + 5'h01 == unitBits);
    assign intRise = (s_r.divCnt == `CCD_HALF_PERIOD - 4'h1) && !s_r.clkOut;
    assign intFall = (s_r.divCnt == `CCD_HALF_PERIOD - 4'h1) && s_r.clkOut;

    always_comb begin
        logic edgeSeen;
        logic [15:0] sample;
        edgeSeen = 1'b0;
        sample = '0;
        s_nxt = s_r;
        if (s_r.wrValid && bufReady) begin
            s_nxt.wrValid = 1'b0;
        end
        case (s_r.phase)
            CCD_IDLE: begin
                s_nxt.clkOut = 1'b0;
                s_nxt.divCnt = '0;
                if (startLoad && !ceSync_r) begin // see [R22]
                    s_nxt.scheme = ccd_scheme_type'(schemeSel); // see [R24]
                    s_nxt.wide = apWordWide;
                    s_nxt.phase = CCD_LOAD;
                    s_nxt.hdrCnt = '0;
                    s_nxt.bitCnt = '0;
                    s_nxt.wordCnt = `CCD_RESET_CNT;
                end
            end
            CCD_LOAD: begin
                // Stall the active clock while the buffer is full so no word is lost
                if (activeMode && !(s_r.wrValid && !bufReady)) begin
                    s_nxt.divCnt = s_r.divCnt + 4'h1;
                    if (intRise || intFall) begin
                        s_nxt.divCnt = '0;
                        s_nxt.clkOut = !s_r.clkOut; // see [R03] [R04]
                    end
                end
                if (s_r.scheme == CCD_AS && intFall && s_r.hdrCnt != `CCD_HDR_BITS) begin
                    s_nxt.hdrCnt = s_r.hdrCnt + 6'h01; // see [R14]
                end
                if (activeMode) begin
                    // Synced data lags two cycles: the bit present at a rise is taken at the next fall
                    edgeSeen = intFall && !(s_r.wrValid && !bufReady)
                        && (s_r.scheme == CCD_AP || s_r.hdrCnt == `CCD_HDR_BITS);
                end else begin
                    // Passive host must hold off while not ready; no pin flags a stall
                    edgeSeen = extRise; // see [R01] [R02]
                end
                if (edgeSeen) begin
                    if (serialMode) begin
                        sample = {s_r.shift[14:0], datSync_r[0]}; // see [R10]
                    end else if (s_r.scheme == CCD_AP && !s_r.wide) begin
                        sample = {8'h00, datSync_r[7:0]}; // see [R19]
                    end else begin
                        sample = datSync_r[15:0]; // see [R15] [R19]
                    end
                    s_nxt.shift = sample;
                    s_nxt.bitCnt = lastBit ? 5'h00 : s_r.bitCnt + 5'h01;
                    if (lastBit) begin
                        s_nxt.wrValid = 1'b1;
                        s_nxt.wrWord.data = sample;
                        s_nxt.wrWord.last = (s_r.wordCnt + 32'h1 == LOAD_WORDS);
                        s_nxt.wordCnt = s_r.wordCnt + 32'h1;
                        if (s_r.wordCnt + 32'h1 == LOAD_WORDS) begin
                            s_nxt.phase = CCD_FINISH;
                        end
                    end
                end
                if (loadError) begin
                    s_nxt.phase = CCD_IDLE;
                end
            end
            CCD_FINISH: begin
                s_nxt.clkOut = 1'b0; // see [R05]
                if (!s_r.wrValid) begin
                    s_nxt.doneRel = 1'b1; // see [R21]
                    s_nxt.phase = CCD_USER;
                end
            end
            CCD_USER: begin
                // Only reset leaves user mode; clock edges here are ignored
                s_nxt.clkOut = 1'b0; // see [R09]
            end
            default: begin
                s_nxt.phase = CCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ***************************************************************
    // Output buffer
    // ***************************************************************
    ccd_skid_buf #(
        .DEPTH(2)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .inValid(s_r.wrValid),
        .inReady(bufReady),
        .inWord(s_r.wrWord),
        .outValid(wordValid),
        .outReady(wordReady),
        .outWord(wordOut)
    );

    // ***************************************************************
    // Pin roles
    // ***************************************************************
    logic inUser;
    logic loading;
    logic [31:0] asCmd;
    assign inUser = (s_r.phase == CCD_USER);
    assign loading = (s_r.phase == CCD_LOAD);
    assign asCmd = {`CCD_READ_CMD, 24'h000000};

    always_comb begin
        config_clock_o = s_r.clkOut;
        config_clock_oe = 1'b0;
        dataPin_o = 2'b00;
        dataPin_oe = 2'b00;
        serial_memory_select_n = 1'b1;
        if (activeMode && (loading || s_r.phase == CCD_FINISH)) begin
            config_clock_oe = 1'b1; // see [R03] [R04]
        end
        if (activeMode && inUser) begin
            config_clock_oe = 1'b1; // see [R05]
            if (userClkOwn) begin
                config_clock_o = userClk.o; // see [R06]
                config_clock_oe = userClk.oe;
            end
        end
        // Passive clock stays input-only: user drive is never honoured, see [R07] [R08]
        if (s_r.scheme == CCD_AS && loading) begin
            serial_memory_select_n = 1'b0; // see [R23]
            dataPin_oe[1] = 1'b1; // see [R14]
            dataPin_o[1] = (s_r.hdrCnt < `CCD_HDR_BITS) ? asCmd[5'd31 - s_r.hdrCnt[4:0]] : 1'b0;
        end
        // Passive serial leaves pin one tri-stated, see [R17]
        if (inUser) begin
            case (s_r.scheme)
                CCD_AS: begin
                    dataPin_o[1] = userData1.o; // see [R16]
                    dataPin_oe[1] = 1'b1;
                    // Pin zero stays input, see [R11]
                end
                CCD_AP: begin
                    dataPin_o = {userData1.o, userData0.o}; // see [R13] [R20]
                    dataPin_oe = {userData1.oe, userData0.oe};
                end
                CCD_FPP: begin
                    dataPin_o = {userData1.o, userData0.o}; // see [R12] [R18]
                    dataPin_oe = {userData1.oe, userData0.oe};
                end
                default: begin
                    dataPin_o[0] = userData0.o; // see [R12]
                    dataPin_oe[0] = userData0.oe;
                end
            endcase
        end
    end

    assign load_complete_flag_o = 1'b0;
    assign load_complete_flag_oe = !s_r.doneRel; // see [R21]
    assign userMode = inUser;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinReadback <= '0;
        end else begin
            pinReadback <= datSync_r;
        end
    end

endmodule // ccd_config_pins

`default_nettype wire

// ===== src/ccd_consts.svh
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// Scheme select codes
`define CCD_SCHEME_PS 2'h0
`define CCD_SCHEME_FPP 2'h1
`define CCD_SCHEME_AS 2'h2
`define CCD_SCHEME_AP 2'h3

// Active-scheme clock divider: half period in ref_clk cycles
`define CCD_HALF_PERIOD 4'h2

// Serial memory read command, sent msb first
`define CCD_READ_CMD 8'h03
`define CCD_CMD_BITS 6'h08
// Command plus 24 address bits
`define CCD_HDR_BITS 6'h20

// Reset values
`define CCD_RESET_CNT 32'h0000_0000

`endif

// ===== src/ccd_pkg.sv
package ccd_pkg;

    typedef enum logic [1:0] {
        CCD_PS,
        CCD_FPP,
        CCD_AS,
        CCD_AP
    } ccd_scheme_type;

    typedef enum logic [2:0] {
        CCD_IDLE,
        CCD_LOAD,
        CCD_FINISH,
        CCD_USER
    } ccd_phase_type;

    typedef struct packed {
        logic [15:0] data;
        logic last;
    } ccd_word_type;

    // Two-signal view of one two-way pin: output value and enable
    typedef struct packed {
        logic o;
        logic oe;
    } ccd_drive_type;

endpackage

// ===== src/ccd_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none

module ccd_skid_buf
    import ccd_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire ccd_word_type inWord,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output ccd_word_type outWord
);

    typedef struct packed {
        ccd_word_type [DEPTH-1:0] mem;
        logic [$clog2(DEPTH)-1:0] wrPtr;
        logic [$clog2(DEPTH)-1:0] rdPtr;
        logic [$clog2(DEPTH):0] count;
    } ccd_buf_state_type;

    ccd_buf_state_type state_r;
    ccd_buf_state_type state_nxt;
    logic doWrite;
    logic doRead;

    assign inReady = (state_r.count != DEPTH[$clog2(DEPTH):0]);
    assign outValid = (state_r.count != '0);
    assign outWord = state_r.mem[state_r.rdPtr];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_comb begin
        state_nxt = state_r;
        if (doWrite) begin
            state_nxt.mem[state_r.wrPtr] = inWord;
            state_nxt.wrPtr = state_r.wrPtr + 1'b1;
        end
        if (doRead) begin
            state_nxt.rdPtr = state_r.rdPtr + 1'b1;
        end
        case ({doWrite, doRead})
            2'b10: state_nxt.count = state_r.count + 1'b1;
            2'b01: state_nxt.count = state_r.count - 1'b1;
            default: state_nxt.count = state_r.count;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule // ccd_skid_buf

`default_nettype wire

// ===== verif/ccd_config_pins_checker.sv
`timescale 1ns/100ps
`default_nettype none

module ccd_config_pins_checker
    import ccd_pkg::*;
#(
    parameter int WORD_BITS = 16,
    parameter logic [31:0] LOAD_WORDS = 32'd4096
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic [1:0] schemeSel,
    input wire logic userClkOwn,
    input wire logic config_clock_o,
    input wire logic config_clock_oe,
    input wire logic [1:0] dataPin_oe,
    input wire logic serial_memory_select_n,
    input wire logic load_complete_flag_oe,
    input wire logic userMode,
    input wire logic wordValid,
    input wire logic wordReady,
    input wire ccd_word_type wordOut
);
    // ****************
    // Pin properties
    // ****************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    pas_clk_a: assert property (!schemeSel[1] |-> !config_clock_oe)
        else $error("passive clock pin driven");
    ps_pin_a: assert property (schemeSel == CCD_PS && !userMode |-> !dataPin_oe[1])
        else $error("pin one driven in serial load");
    sel_a: assert property (schemeSel != CCD_AS |-> serial_memory_select_n)
        else $error("memory select low outside serial");
    cmd_out_a: assert property (!serial_memory_select_n |-> dataPin_oe[1])
        else $error("command pin not driven");
    sel_low_a: assert property (schemeSel == CCD_AS && !userMode && $rose(config_clock_o)
        |-> !serial_memory_select_n) else $error("memory not selected");
    clk_half_a: assert property (schemeSel[1] && !userMode && $rose(config_clock_o)
        |-> config_clock_o[*2]) else $error("clock high phase short");
    idle_clk_a: assert property (schemeSel[1] && userMode && !userClkOwn
        |-> config_clock_oe && !config_clock_o) else $error("clock not parked");
    done_a: assert property (userMode |-> !load_complete_flag_oe)
        else $error("done still pulled low");
    stay_a: assert property (userMode |=> userMode)
        else $error("user mode left");
    hold_a: assert property (wordValid && !wordReady |=> wordValid && $stable(wordOut))
        else $error("stalled word changed");
    cover property (userMode && schemeSel == CCD_PS);
    cover property (userMode && schemeSel == CCD_AS);
    cover property (wordValid && !wordReady && schemeSel == CCD_AP);
endmodule // ccd_config_pins_checker

bind ccd_config_pins ccd_config_pins_checker #(.WORD_BITS(WORD_BITS), .LOAD_WORDS(LOAD_WORDS)) chk_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .schemeSel(schemeSel), .userClkOwn(userClkOwn),
    .config_clock_o(config_clock_o), .config_clock_oe(config_clock_oe), .dataPin_oe(dataPin_oe),
    .serial_memory_select_n(serial_memory_select_n), .load_complete_flag_oe(load_complete_flag_oe),
    .userMode(userMode), .wordValid(wordValid), .wordReady(wordReady), .wordOut(wordOut));

`default_nettype wire

// ===== verif/ccd_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ccd_host_model
    import ccd_pkg::*;
#(
    parameter int NW = 4
) (
    // Bench control
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [1:0] scheme,
    input wire logic wide,
    input wire logic [15:0] base,
    // Pin wires
    input wire logic clkPin,
    input wire logic cmdPin,
    output logic hostClk,
    output logic [15:0] hostData,
    output logic [31:0] cmdSeen
);
    // ****************
    // Host and memory
    // ****************
    logic tog = 1'b0;
    logic ser;
    logic [15:0] w;
    int m = 0;
    int idx = 0;
    int rises = 0;
    int k;
    initial begin
        hostClk = 1'b0;
        cmdSeen = 32'h0;
    end
    always @(posedge ref_clk) tog <= ~tog;
    assign ser = scheme == CCD_AS || scheme == CCD_PS;
    assign w = base + 16'(ser ? idx / 16 : idx);
    // Lines nobody owns show a moving pattern, never a stale value
    always_comb begin
        hostData = w;
        if (ser) hostData = {{15{tog}}, w[15 - idx % 16]};
        if (scheme == CCD_AP && !wide) hostData = {{8{tog}}, w[7:0]};
        if (!go) hostData = {16{tog}};
    end
    // Passive host: 160 ns clock, data set half a period before each rise
    always @(posedge go) begin
        if (!scheme[1]) begin
            #13;
            for (k = 0; k < (ser ? NW * 16 : NW); k++) begin
                idx = k;
                #80 hostClk = 1'b1;
                #80 hostClk = 1'b0;
            end
        end
    end // Clock rests low afterwards
    // Memory: header captured on rises, data changed after falls
    always @(posedge clkPin) begin
        if (go && scheme[1]) begin
            if (scheme == CCD_AS && rises < 32) cmdSeen = {cmdSeen[30:0], cmdPin};
            else m = m + 1;
            rises = rises + 1;
        end
    end
    always @(negedge clkPin) if (go && scheme[1]) idx = m;
    always @(negedge go) begin
        m = 0;
        idx = 0;
        rises = 0;
        cmdSeen = 32'h0;
    end
endmodule // ccd_host_model

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccd_consts.svh"

module tb
    import ccd_pkg::*;
;
    // ****************
    // Bench
    // ****************
    localparam int NW = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] schemeSel = 2'h0;
    logic apWordWide = 1'b0;
    logic startLoad = 1'b0;
    logic userClkOwn = 1'b0;
    ccd_drive_type userClk = '0;
    ccd_drive_type userData0 = '0;
    ccd_drive_type userData1 = '0;
    logic wordReady = 1'b0;
    logic go = 1'b0;
    logic poke = 1'b0;
    logic tbClk = 1'b0;
    logic [15:0] base = 16'h0;
    logic clkPin, pin0, pin1, clkO, clkOe, selN, flagO, flagOe, userMode, wordValid, hostClk;
    logic [1:0] dO, dOe;
    logic [15:0] hostData;
    logic [15:0] pinRb;
    logic [31:0] cmdSeen;
    ccd_word_type wordOut;
    int failures = 0;
    int checked = 0;
    initial forever #10 ref_clk = ~ref_clk;
    // Pull-up holds the clock pin high when nobody drives it
    assign clkPin = clkOe ? clkO : (poke ? tbClk : (schemeSel[1] ? 1'b1 : hostClk));
    assign pin0 = dOe[0] ? dO[0] : hostData[0];
    assign pin1 = dOe[1] ? dO[1] : hostData[1];
    ccd_config_pins #(.WORD_BITS(16), .LOAD_WORDS(32'd4)) ccd_config_pins_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .schemeSel(schemeSel), .apWordWide(apWordWide),
        .startLoad(startLoad), .loadError(1'b0), .chip_enable_in_n(1'b0),
        .userClkOwn(userClkOwn), .userClk(userClk), .userData0(userData0), .userData1(userData1),
        .config_clock_i(clkPin), .config_clock_o(clkO), .config_clock_oe(clkOe),
        .dataPin_i({hostData[15:2], pin1, pin0}), .dataPin_o(dO), .dataPin_oe(dOe),
        .serial_memory_select_n(selN), .load_complete_flag_o(flagO), .load_complete_flag_oe(flagOe),
        .userMode(userMode), .pinReadback(pinRb), .wordValid(wordValid), .wordReady(wordReady), .wordOut(wordOut));
    ccd_host_model #(.NW(NW)) ccd_host_model_inst (
        .ref_clk(ref_clk), .go(go), .scheme(schemeSel), .wide(apWordWide), .base(base), .clkPin(clkPin),
        .cmdPin(pin1), .hostClk(hostClk), .hostData(hostData), .cmdSeen(cmdSeen));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [16:0] expWord(int k);
        logic [15:0] w;
        w = base + 16'(k);
        if (schemeSel == CCD_AP && !apWordWide) w = {8'h00, w[7:0]};
        return {w, k == NW - 1};
    endfunction
    task run(input logic [1:0] sc, input logic wd, input logic own);
        int n;
        int t;
        @(posedge ref_clk);
        #2 rst_b = 1'b0;
        go = 1'b0;
        schemeSel = sc;
        apWordWide = wd;
        userClkOwn = own;
        userClk = '{o: 1'b1, oe: 1'b1};
        userData0 = ccd_drive_type'(2'($urandom % 4));
        userData1 = ccd_drive_type'(2'($urandom % 4));
        base = 16'($urandom);
        repeat (2) @(posedge ref_clk);
        #2 rst_b = 1'b1;
        repeat (3) @(posedge ref_clk);
        #2 startLoad = 1'b1;
        go = 1'b1;
        n = 0;
        t = 0;
        // Active loads stall at first so the AP buffer fills and refuses; AS is still sending its header then
        while (n < NW && t < 20000) begin
            @(posedge ref_clk);
            #2 startLoad = 1'b0;
            wordReady = (sc[1] && t < 40) ? 1'b0 : ($urandom % 4 != 0);
            t++;
            @(negedge ref_clk);
            if (wordValid === 1'b1 && wordReady === 1'b1) begin
                check(32'(wordOut), 32'(expWord(n)));
                n++;
            end
        end
        t = 0;
        while (userMode !== 1'b1 && t < 200) begin
            @(negedge ref_clk);
            t++;
        end
        if (userMode !== 1'b1 || n < NW) begin
            failures++;
            report_and_stop();
        end
        repeat (3) @(negedge ref_clk);
        check(32'({flagO, flagOe}), 32'h0);
        check(32'(clkOe), 32'(sc[1]));
        check(32'(pinRb[0]), 32'(pin0));
        if (sc[1]) check(32'(clkO), 32'(own));
        if (!sc[1]) check(32'(dOe[0]), 32'(userData0.oe));
        if (sc == CCD_FPP) check(32'(dOe[1]), 32'(userData1.oe));
        if (sc == CCD_AS) check(cmdSeen, {`CCD_READ_CMD, 24'h000000});
        if (sc == CCD_AS) check(32'({dOe, dO[1]}), 32'({2'b10, userData1.o}));
        if (sc == CCD_AP) check(32'({dOe, dO}), 32'({userData1.oe, userData0.oe, userData1.o, userData0.o}));
        poke = 1'b1;
        repeat (20) begin
            repeat (4) @(posedge ref_clk);
            #2 tbClk = ~tbClk;
        end
        poke = 1'b0;
        check(32'({userMode, wordValid}), 32'h2);
        $display("test scheme %0d wide %0d done", sc, wd);
    endtask
    initial begin
        void'($urandom(32'h32b1));
        run(CCD_PS, 1'b0, 1'b0);
        run(CCD_FPP, 1'b0, 1'b0);
        run(CCD_AS, 1'b0, 1'b0);
        run(CCD_AP, 1'b0, 1'b0);
        run(CCD_AP, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
